// [hdl/serial_eeprom_access_engine.v]
// Two-wire serial EEPROM slave: command logic, page buffer, write cycle
//
// Overview of operation
// - Control byte: code 1010, three selects, direction
// - Respond only when selects match select pins
// - Top two word-address bits are ignored
// - Sequential reads never leave this device
// - Write control byte acked, then address high
// - Both address bytes load pointer, each acked
// - Stop starts programming; no acks while busy
// - Write-protected write acked, skipped, ready at once
// - After byte write pointer is one past
// - Page write buffers bytes, commits after Stop
// - Only low six pointer bits increment per byte
// - Page crossing wraps to start of page
// - Write-protect sampled only at the Stop
// - Read control byte sends byte at pointer
// - Master nack ends read; data line released
// - Repeated Start after address aborts the write
// - After random read pointer is one past
// - Master ack sends next byte, pointer increments
// - Pointer wraps from top address to zero
`timescale 1ns/1ps
`include "eeprom_map.vh"
module serial_eeprom_access_engine #(
  parameter ADDR_W = `ADDR_WIDTH,
  parameter PAGE_W = `PAGE_WIDTH,
  parameter [31:0] WRITE_CYCLES = `WRITE_CYCLE_COUNT
) (
  input wire ref_clk,
  input wire rst,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire write_protect,
  input wire chip_select_bit_low,
  input wire chip_select_bit_mid,
  input wire chip_select_bit_high,
  output reg write_busy
);

  ////////////////////////////////////////////////////////////////////////
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CTRL = 3'h1;
  localparam [2:0] ST_ADRH = 3'h2;
  localparam [2:0] ST_ADRL = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDACK = 3'h5;
  localparam [2:0] ST_READ = 3'h6;

  localparam [1:0] W_IDLE = 2'h0;
  localparam [1:0] W_DRAIN = 2'h1;
  localparam [1:0] W_WALK = 2'h2;
  localparam [1:0] W_TIME = 2'h3;

  localparam PAGES = 1 << PAGE_W;
  localparam BASE_W = ADDR_W - PAGE_W;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; second stage feeds logic, third stage (scl_d, sda_d) feeds edge and Start/Stop detection
  reg scl_m, scl_s, scl_d;
  reg sda_m, sda_s, sda_d;
  reg wp_m, wp_s;
  reg [2:0] cs_m, cs_s;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      wp_m <= 1'b0;
      wp_s <= 1'b0;
      cs_m <= 3'h0;
      cs_s <= 3'h0;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      wp_m <= write_protect;
      wp_s <= wp_m;
      cs_m <= {chip_select_bit_high, chip_select_bit_mid,
        chip_select_bit_low};
      cs_s <= cs_m;
    end
  end

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire bus_start = scl_s && scl_d && sda_d && !sda_s;
  wire bus_stop = scl_s && scl_d && !sda_d && sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Storage: array, page buffer and its per-entry valid bits
  reg [7:0] mem [0:(1<<ADDR_W)-1];
  reg [7:0] pbuf [0:PAGES-1];
  reg [PAGES-1:0] pvalid;

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] rx_sh;
  reg [7:0] tx_sh;
  reg [ADDR_W-1:0] ptr;
  reg [BASE_W-1:0] page_base;
  reg have_data;
  reg [1:0] wr_state;
  reg [PAGE_W-1:0] walk_idx;
  reg [31:0] timer;

  wire [7:0] rd_byte = mem[ptr];
  wire busy = (wr_state != W_IDLE);
  wire walking = (wr_state == W_WALK);

  // Buffer between the byte receiver and the page buffer
  reg push_valid;
  reg [PAGE_W+7:0] push_data;
  wire push_ready;
  wire drain_valid;
  wire [PAGE_W+7:0] drain_data;
  // The page buffer is frozen while it is being committed
  wire drain_ready = !walking;
  wire drain_fire = drain_valid && drain_ready;

  pair_buffer #(
    .WIDTH(PAGE_W + 8),
    .DEPTH(2),
    .PTR_W(1)
  ) u_rx_buffer (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_data)
  );

  wire [7:0] drain_byte = drain_data[7:0];
  wire [PAGE_W-1:0] drain_idx = drain_data[PAGE_W+7:8];

  ////////////////////////////////////////////////////////////////////////
  // Array and page buffer writes carry no reset
  always @(posedge ref_clk) begin
    if (drain_fire) begin
      pbuf[drain_idx] <= drain_byte;
    end
    if (walking && pvalid[walk_idx]) begin
      mem[{page_base, walk_idx}] <= pbuf[walk_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control byte decode
  wire ctrl_code_ok =
    (rx_sh[`CTRL_CODE_MSB:`CTRL_CODE_LSB] == `CTRL_CODE);
  wire ctrl_cs_ok =
    (rx_sh[`CTRL_CS_MSB:`CTRL_CS_LSB] == cs_s);
  wire ctrl_read = rx_sh[`CTRL_RW_BIT];
  // A busy device answers nothing, polling bytes included
  wire ctrl_hit = ctrl_code_ok && ctrl_cs_ok && !busy;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      ptr <= `PTR_RESET;
      page_base <= {BASE_W{1'b0}};
      have_data <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      push_valid <= 1'b0;
      push_data <= {(PAGE_W+8){1'b0}};
      pvalid <= {PAGES{1'b0}};
      wr_state <= W_IDLE;
      walk_idx <= {PAGE_W{1'b0}};
      timer <= 32'h0;
      write_busy <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      push_valid <= 1'b0;
      write_busy <= busy;
      if (drain_fire) begin
        pvalid[drain_idx] <= 1'b1;
      end

      // Self-timed commit: drain, copy page, then wait out the cycle
      case (wr_state)
        W_IDLE: begin
        end
        W_DRAIN: begin
          if (!drain_valid && !push_valid) begin
            wr_state <= W_WALK;
            walk_idx <= {PAGE_W{1'b0}};
          end
        end
        W_WALK: begin
          walk_idx <= walk_idx + 1'b1;
          if (walk_idx == PAGES[PAGE_W-1:0] - 1'b1) begin
            wr_state <= W_TIME;
            timer <= 32'h0;
          end
        end
        W_TIME: begin
          timer <= timer + 32'h1;
          if (timer >= WRITE_CYCLES - 32'h1) begin
            wr_state <= W_IDLE;
            pvalid <= {PAGES{1'b0}};
          end
        end
        default: begin
          wr_state <= W_IDLE;
        end
      endcase

      if (bus_start) begin
        // A repeated Start throws away any unfinished write data
        state <= ST_CTRL;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        have_data <= 1'b0;
        if (!busy) begin
          pvalid <= {PAGES{1'b0}};
        end
      end else if (bus_stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        if (state == ST_WDATA && have_data && !(|ptr[PAGE_W-1:0])) begin
          ptr[ADDR_W-1:PAGE_W] <= page_base + 1'b1;
        end
        if (state == ST_WDATA && have_data && !busy) begin
          if (wp_s) begin
            // Protected: nothing programmed, next command welcome
            pvalid <= {PAGES{1'b0}};
          end else begin
            wr_state <= W_DRAIN;
          end
        end
      end else if (state == ST_IDLE) begin
        // Bus ignored until the next Start
        sda_oe <= 1'b0;
      end else if (state == ST_READ) begin
        if (scl_rise) begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == `BIT_ACK && sda_s) begin
            state <= ST_IDLE;
          end
        end else if (scl_fall) begin
          if (bit_cnt == `BIT_ACK) begin
            sda_oe <= 1'b0;
          end else if (bit_cnt == `BIT_DONE) begin
            // Master acked: next byte, pointer wraps inside device
            tx_sh <= rd_byte;
            sda_oe <= !rd_byte[7];
            ptr <= ptr + 1'b1;
            bit_cnt <= 4'h0;
          end else begin
            tx_sh <= {tx_sh[6:0], 1'b0};
            sda_oe <= !tx_sh[6];
          end
        end
      end else if (scl_rise) begin
        if (bit_cnt < `BIT_ACK) begin
          rx_sh <= {rx_sh[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (scl_fall) begin
        if (bit_cnt == `BIT_ACK) begin
          bit_cnt <= `BIT_DONE;
          case (state)
            ST_CTRL: begin
              if (!ctrl_hit) begin
                state <= ST_IDLE;
              end else if (ctrl_read) begin
                sda_oe <= 1'b1;
                state <= ST_RDACK;
              end else begin
                sda_oe <= 1'b1;
                state <= ST_ADRH;
              end
            end
            ST_ADRH: begin
              sda_oe <= 1'b1;
              ptr[ADDR_W-1:8] <= rx_sh[`ADDR_HI_MSB:0];
              state <= ST_ADRL;
            end
            ST_ADRL: begin
              sda_oe <= 1'b1;
              ptr[7:0] <= rx_sh;
              state <= ST_WDATA;
            end
            ST_WDATA: begin
              // Full buffer withholds the ack rather than lose a byte
              if (push_ready) begin
                sda_oe <= 1'b1;
                push_valid <= 1'b1;
                push_data <= {ptr[PAGE_W-1:0], rx_sh};
                page_base <= ptr[ADDR_W-1:PAGE_W];
                have_data <= 1'b1;
                // Low bits only: overrun wraps within the page
                ptr[PAGE_W-1:0] <=
                  ptr[PAGE_W-1:0] + 1'b1;
              end
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end else if (bit_cnt == `BIT_DONE) begin
          bit_cnt <= 4'h0;
          if (state == ST_RDACK) begin
            tx_sh <= rd_byte;
            sda_oe <= !rd_byte[7];
            ptr <= ptr + 1'b1;
            state <= ST_READ;
          end else begin
            sda_oe <= 1'b0;
          end
        end
      end
    end
  end

endmodule // serial_eeprom_access_engine

// [hdl/eeprom_map.vh]
// Constants of the two-wire serial EEPROM access engine
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH

// Control byte layout
`define CTRL_CODE 4'ha
`define CTRL_CODE_MSB 7
`define CTRL_CODE_LSB 4
`define CTRL_CS_MSB 3
`define CTRL_CS_LSB 1
`define CTRL_RW_BIT 0

// Word address: only the low bits of the high byte are kept
`define ADDR_WIDTH 14
`define ADDR_HI_MSB 5
`define PTR_RESET 14'h0000

// Page buffer
`define PAGE_WIDTH 6
`define PAGE_BYTES 64

// Bit counter values inside one byte slot
`define BIT_ACK 4'h8
`define BIT_DONE 4'h9

// Self-timed programming cycle
`define CLK_PERIOD_NS 5
`define WRITE_TIME_NS 5000000
`define WRITE_CYCLE_COUNT (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

// [hdl/pair_buffer.v]
// Two-entry valid/ready buffer between byte receiver and page buffer
`timescale 1ns/1ps
module pair_buffer #(
  parameter WIDTH = 14,
  parameter DEPTH = 2,
  parameter PTR_W = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] slot [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[PTR_W:0]);
  assign out_valid = (count != {(PTR_W+1){1'b0}});
  assign out_data = slot[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Slots carry no reset; the count alone says what is valid
  always @(posedge ref_clk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[PTR_W-1:0] - 1'b1) ?
          {PTR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[PTR_W-1:0] - 1'b1) ?
          {PTR_W{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // pair_buffer

// [tb/eeprom_bus_checker.sv]
// Port assertions for the serial EEPROM access engine
`timescale 1ns/1ps
module eeprom_bus_checker #(
  parameter [31:0] WRITE_CYCLES = 32'd200
) (
  input wire ref_clk,
  input wire rst,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire write_protect,
  input wire chip_select_bit_low,
  input wire chip_select_bit_mid,
  input wire chip_select_bit_high,
  input wire write_busy
);
  logic [31:0] busy_cnt;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Length of the running programming cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      busy_cnt <= 32'h0;
    else if (write_busy)
      busy_cnt <= busy_cnt + 32'h1;
    else
      busy_cnt <= 32'h0;
  end
  //////////////////////////////////////////////////////////////////////
  chk_drive_zero: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  chk_drive_low_clk: assert property ($rose(sda_oe) |-> !scl)
    else $error("data drive began with clock high");
  chk_drive_holds: assert property ($rose(sda_oe) |-> sda_oe [*4])
    else $error("data drive too short");
  chk_busy_silent: assert property (write_busy |-> !sda_oe)
    else $error("acknowledge while busy");
  chk_busy_min: assert property ($fell(write_busy) |->
    busy_cnt >= WRITE_CYCLES)
    else $error("programming cycle too short");
  chk_busy_max: assert property (write_busy |->
    busy_cnt < WRITE_CYCLES + 32'd300)
    else $error("programming cycle too long");
  chk_stop_release: assert property (
    (scl && $past(scl) && $rose(sda_in)) |-> ##[0:4] !sda_oe)
    else $error("data line held after stop");
  chk_protect_idle: assert property (
    $rose(write_busy) |-> !$past(write_protect, 4))
    else $error("programming while protected");
endmodule // eeprom_bus_checker

bind serial_eeprom_access_engine eeprom_bus_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) chk (
  .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
  .chip_select_bit_low(chip_select_bit_low),
  .chip_select_bit_mid(chip_select_bit_mid),
  .chip_select_bit_high(chip_select_bit_high),
  .write_busy(write_busy)
);

// [tb/bus_master.sv]
// Two-wire bus master model for the EEPROM bench
`timescale 1ns/1ps
module bus_master (
  input wire sda,
  output logic scl,
  output logic sda_rel
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // One quarter of the 48 ns bus period
  task automatic step(input logic c, input logic d);
    scl = c;
    sda_rel = d;
    #12;
  endtask
  // Also serves as repeated start from mid-frame
  task automatic start;
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b1, 1'b1);
  endtask
  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    step(1'b0, b);
    step(1'b1, b);
    s = sda;
    step(1'b1, b);
    step(1'b0, b);
  endtask
  // Most significant bit first, then the ninth clock
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
    output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, s);
    ack = (s === 1'b0);
  endtask
endmodule // bus_master

// [tb/test_serial_eeprom_access_engine.sv]
// Self-checking bench for the serial EEPROM access engine
`timescale 1ns/1ps
module test_serial_eeprom_access_engine;
  localparam logic [2:0] CS = 3'b101;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] cs = CS;
  logic scl, sda_rel, sda_out, sda_oe, write_busy, ack;
  logic [7:0] rd;
  int mismatches = 0;
  int samples_checked = 0;
  // Open drain with pull-up
  wire sda = (sda_oe ? sda_out : 1'b1) && sda_rel;
  always #2.5 ref_clk = ~ref_clk;
  bus_master m (.sda(sda), .scl(scl), .sda_rel(sda_rel));
  serial_eeprom_access_engine #(.WRITE_CYCLES(32'd200)) dut (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(wp),
    .chip_select_bit_low(cs[0]), .chip_select_bit_mid(cs[1]),
    .chip_select_bit_high(cs[2]), .write_busy(write_busy)
  );
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [7:0] s,
    input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic ck1(input string w, input logic s, input logic e);
    check(w, {7'h0, s}, {7'h0, e});
  endtask
  task automatic tx(input logic [7:0] d);
    m.byte_io(d, 1'b1, rd, ack);
  endtask
  task automatic set_addr(input logic [15:0] a);
    m.start;
    tx({4'ha, CS, 1'b0});
    ck1("write control ack", ack, 1'b1);
    tx(a[15:8]);
    ck1("high address ack", ack, 1'b1);
    tx(a[7:0]);
    ck1("low address ack", ack, 1'b1);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
    set_addr(a);
    foreach (d[i]) begin
      tx(d[i]);
      ck1("data ack", ack, 1'b1);
    end
    m.stop;
  endtask
  // Poll with write control bytes until acknowledged
  task automatic poll(input logic busy_exp);
    int n;
    n = 0;
    ack = 1'b0;
    repeat (8) @(posedge ref_clk);
    ck1("write busy", write_busy, busy_exp);
    // Bus steps then fall on whole nanoseconds, clear of rising clock edges
    #0.5;
    while (!ack && n < 20) begin
      m.start;
      tx({4'ha, CS, 1'b0});
      n++;
    end
    m.stop;
    ck1("refused while busy", n > 1, busy_exp);
    ck1("poll acked", ack, 1'b1);
  endtask
  task automatic rdseq(input logic [7:0] e[$]);
    m.start;
    tx({4'ha, CS, 1'b1});
    ck1("read control ack", ack, 1'b1);
    foreach (e[i]) begin
      m.byte_io(8'hff, i == e.size() - 1, rd, ack);
      check("read data", rd, e[i]);
    end
    m.stop;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_write_read;
    wr(16'h0000, {8'h42});
    poll(1'b1);
    // Top address bits ignored; page wrap puts 99 at 3fc0
    wr(16'hfffe, {8'h77, 8'h88, 8'h99});
    poll(1'b1);
    wr(16'h3fbf, {8'h55});
    poll(1'b1);
    rdseq({8'h99});
    set_addr(16'hbffe);
    rdseq({8'h77, 8'h88, 8'h42});
    set_addr(16'h3fbf);
    rdseq({8'h55});
    rdseq({8'h99});
    $display("test write_read done");
  endtask
  task automatic t_protect;
    @(posedge ref_clk);
    wp <= 1'b1;
    #0.5;
    wr(16'h3fbf, {8'h00});
    @(posedge ref_clk);
    wp <= 1'b0;
    poll(1'b0);
    set_addr(16'h3fbf);
    rdseq({8'h55});
    $display("test protect done");
  endtask
  task automatic t_page_roll;
    logic [7:0] q[$];
    for (int k = 0; k < 66; k++) begin
      q.push_back(8'(k));
    end
    wr(16'h0040, q);
    poll(1'b1);
    set_addr(16'h0040);
    rdseq({8'h40, 8'h41, 8'h02});
    $display("test page_roll done");
  endtask
  task automatic t_select;
    for (int b = 0; b < 3; b++) begin
      m.start;
      tx({4'ha, CS ^ (3'b001 << b), 1'b1});
      ck1("foreign select", ack, 1'b0);
      tx(8'h00);
      ck1("ignored until start", ack, 1'b0);
    end
    m.start;
    tx({4'hb, CS, 1'b0});
    ck1("foreign code", ack, 1'b0);
    m.stop;
    $display("test select done");
  endtask
  // Straps 100: all three select bits must match, so select 000 is ignored
  task automatic t_expand;
    @(posedge ref_clk);
    cs <= 3'b100;
    repeat (4) @(posedge ref_clk);
    #0.5;
    m.start;
    tx({4'ha, 3'b100, 1'b0});
    ck1("upper device ack", ack, 1'b1);
    m.start;
    tx({4'ha, 3'b000, 1'b0});
    ck1("lower device silent", ack, 1'b0);
    m.stop;
    $display("test expand done");
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #0.5;
    t_write_read;
    t_protect;
    t_page_roll;
    t_select;
    t_expand;
    end_of_test;
  end
endmodule // test_serial_eeprom_access_engine
